// *** core/mlc_host.sv ***
/*
  host end: axi4-lite slave with command, status, pin and sense
  registers; a two-wire master that reads and writes one module byte.
  assumes pull-ups on the open-drain lines are resolved in the link.
*/
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mlc_host (
  input wire logic core_clk,
  input wire logic srst,
  mlc_link_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import mlc_pkg::*;
  typedef enum logic [1:0] {
    MLH_IDLE = 2'h0, MLH_RUN = 2'h1
  } mlh_st_t;
  // sense pins pass three flops
  logic [2:0] prs_s_q, int_s_q, sda_s_q;
  logic prs_f_q, int_f_q, sda_f_q;
  always_ff @(posedge core_clk) begin
    prs_s_q <= {prs_s_q[1:0], link.present_n};
    int_s_q <= {int_s_q[1:0], link.int_n};
    sda_s_q <= {sda_s_q[1:0], link.sda};
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prs_f_q <= 1'b1;
      int_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      if (prs_s_q[1] == prs_s_q[2]) prs_f_q <= prs_s_q[2];
      if (int_s_q[1] == int_s_q[2]) int_f_q <= int_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
    end
  end
  // pin register: select high (off), reset high, low power on
  logic [2:0] pins_q;
  // command / status
  logic busy_q, nack_q, wr_q;
  logic [7:0] idx_q, wdat_q, rdat_q;
  // axi write path: take address and data in either order
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  wire wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire cmd_go = wr_fire && aw_q == HOFS_CMD && w_q[CMD_GO_BIT] && !busy_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q == HOFS_CMD || aw_q == HOFS_PINS)
          ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
    end
  end
  // pins register; select drives one module (host keeps one per slot)
  always_ff @(posedge core_clk) begin
    if (srst) pins_q <= 3'b111;
    else if (wr_fire && aw_q == HOFS_PINS && s_axi_wstrb[0])
      pins_q <= w_q[2:0];
  end
  // axi read path
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready
        && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          HOFS_CMD: s_axi_rdata <= {16'h0, idx_q, wdat_q};
          HOFS_STAT: s_axi_rdata <= {22'h0, nack_q, busy_q, rdat_q};
          HOFS_PINS: s_axi_rdata <= {29'h0, pins_q};
          HOFS_SENSE: s_axi_rdata <= {30'h0, int_f_q, prs_f_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end
  // two-wire master: a fixed sequence of half-bit steps
  // sequence: start, addr+w, idx, (write: data | read: rstart,
  // addr+r, data nack), stop. byte slots of 9 clocks each.
  mlh_st_t st_q;
  logic [$clog2(SCL_HALF_CYC+1)-1:0] tdiv_q;
  logic [7:0] step_q; // half-period step number
  logic scl_q, sda_oe_q;
  wire tick = tdiv_q == SCL_HALF_CYC[$bits(tdiv_q)-1:0];
  // bit to send in a frame: returns 1 for released line
  function automatic logic frame_bit(input logic [7:0] b,
    input logic [3:0] n);
    frame_bit = (n < 4'h8) ? b[7 - n[2:0]] : 1'b1;
  endfunction
  logic [3:0] slot; // bit within byte slot
  logic [2:0] byten; // byte slot number
  logic [7:0] tx;
  always_comb begin
    // odd step n sets the bit that the rise at step n+1 samples
    slot = 4'(((step_q - 8'd1) >> 1) % 8'd9);
    byten = 3'(((step_q - 8'd1) >> 1) / 8'd9);
    unique case (byten)
      3'd0: tx = {DEV_ADDR, 1'b0};
      3'd1: tx = idx_q;
      3'd2: tx = wr_q ? wdat_q : 8'hff;
      default: tx = 8'hff;
    endcase
  end
  wire [7:0] last = wr_q ? 8'd56 : 8'd96; // final step count
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= MLH_IDLE;
      tdiv_q <= '0;
      step_q <= 8'h00;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      wr_q <= 1'b0;
      idx_q <= 8'h00;
      wdat_q <= 8'h00;
      rdat_q <= 8'h00;
    end else if (st_q == MLH_IDLE) begin
      if (cmd_go) begin
        st_q <= MLH_RUN;
        busy_q <= 1'b1;
        nack_q <= 1'b0;
        wr_q <= w_q[CMD_WR_BIT];
        idx_q <= w_q[15:8];
        wdat_q <= w_q[7:0];
        step_q <= 8'h00;
        tdiv_q <= '0;
        sda_oe_q <= 1'b1; // start: sda falls while scl high
      end
    end else begin
      tdiv_q <= tick ? '0 : tdiv_q + 1'b1;
      if (tick) begin
        step_q <= step_q + 8'h01;
        if (step_q == 8'd0) scl_q <= 1'b0;
        else if (step_q >= last) begin // stop
          scl_q <= 1'b1;
          if (step_q == last + 8'd1) sda_oe_q <= 1'b0;
          if (step_q == last + 8'd2) begin
            st_q <= MLH_IDLE;
            busy_q <= 1'b0;
          end
        end else if (step_q == last - 8'd1) begin
          sda_oe_q <= 1'b1; // hold low before stop
          scl_q <= 1'b0;
        end else if (!wr_q && step_q == 8'd38) begin
          sda_oe_q <= 1'b0; // repeated start setup
          scl_q <= 1'b1;
        end else if (!wr_q && step_q == 8'd39) begin
          sda_oe_q <= 1'b1;
        end else if (!wr_q && step_q == 8'd40) begin
          scl_q <= 1'b0;
          step_q <= 8'd59; // continue with addr+r slot pattern
        end else if (step_q[0]) begin
          scl_q <= 1'b0;
          if (!wr_q && step_q >= 8'd59)
            sda_oe_q <= !frame_bit(step_q < 8'd77 ? {DEV_ADDR, 1'b1}
              : 8'hff, 4'(((step_q - 8'd59) >> 1) % 8'd9));
          else sda_oe_q <= !frame_bit(tx, slot);
        end else begin
          scl_q <= 1'b1;
          // sample acknowledge slots (all but the addr+r one) and read data on rising scl
          if (slot == 4'h8 && sda_f_q && (wr_q || step_q < 8'd40))
            nack_q <= 1'b1;
          if (!wr_q && step_q > 8'd77 && step_q < 8'd93)
            rdat_q <= {rdat_q[6:0], sda_f_q};
        end
      end
    end
  end
  assign link.scl_o_host = scl_q;
  assign link.scl_oe_host = 1'b1;
  assign link.sda_oe_host = sda_oe_q;
  assign link.sel_n = pins_q[PIN_SEL_BIT];
  assign link.rst_n = pins_q[PIN_RST_BIT];
  assign link.lp_sel = pins_q[PIN_LP_BIT];
endmodule
`default_nettype wire

// *** core/mlc_pkg.sv ***
/*
  shared constants for the module low-speed control link: two-wire
  bus framing, device address, register indices of the module-side
  memory map, host-side register offsets and timing counts.
  assumes a 50 mhz core clock on both ends.
*/
package mlc_pkg;
  // core clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 20;
  // two-wire clock half period at the host, in ns
  localparam int unsigned SCL_HALF_NS = 2500;
  // half period in core cycles, rounded down, at least one
  localparam int unsigned SCL_HALF_CYC =
    (SCL_HALF_NS / CLK_PERIOD_NS) > 0 ? SCL_HALF_NS / CLK_PERIOD_NS : 1;
  // least low time on the reset pin that counts as a reset, ns
  localparam int unsigned RST_MIN_NS = 1000;
  // least reset pulse in core cycles, rounded up
  localparam int unsigned RST_MIN_CYC =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // module initialisation time after reset, in cycles (shortenable)
  localparam int unsigned INIT_CYC = 64;
  // seven-bit two-wire device address of the module
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // module memory map, byte index
  localparam logic [7:0] IDX_STATUS = 8'h02; // bit0 data not ready
  localparam logic [7:0] IDX_FLAGS = 8'h03;  // bit0 reset done latch
  localparam logic [7:0] IDX_CTRL = 8'h5d;   // bit0 force low power
  localparam int unsigned MAP_DEPTH = 128;
  localparam int unsigned STATUS_DNR_BIT = 0;
  localparam int unsigned FLAG_RSTDONE_BIT = 0;
  localparam int unsigned CTRL_LP_BIT = 0;
  // host axi register offsets
  localparam logic [7:0] HOFS_CMD = 8'h00;   // w: [7:0] data [15:8] idx
                                             // [16] write [31] go
  localparam logic [7:0] HOFS_STAT = 8'h04;  // r: busy, nack, rdata
  localparam logic [7:0] HOFS_PINS = 8'h08;  // rw: select, reset, lp
  localparam logic [7:0] HOFS_SENSE = 8'h0c; // r: present, interrupt
  localparam int unsigned CMD_GO_BIT = 31;
  localparam int unsigned CMD_WR_BIT = 16;
  // pins register field positions
  localparam int unsigned PIN_SEL_BIT = 0;
  localparam int unsigned PIN_RST_BIT = 1;
  localparam int unsigned PIN_LP_BIT = 2;
  // axi answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** core/mlc_link_if.sv ***
/*
  the seven low-speed pins, one of them the module ground contact for present.
  open-drain lines are resolved here from the output enables; pull-ups
  on the host board are modelled by the wired-and.
*/
`timescale 1ns/100ps
`default_nettype none
interface mlc_link_if;
  logic scl_o_host;   // host drives scl, low when 0
  logic scl_oe_host;
  logic sda_oe_host;  // host pulls sda low
  logic sda_oe_dev;   // module pulls sda low
  logic sel_n;        // module_select_n from host
  logic rst_n;        // module_reset_n from host
  logic lp_sel;       // low_power_select from host
  logic present_oe;   // module grounds module_present_n
  logic int_oe;       // module pulls host_interrupt_n low
  logic scl;          // resolved lines
  logic sda;
  logic present_n;
  logic int_n;
  assign scl = !(scl_oe_host && !scl_o_host);
  assign sda = !(sda_oe_host || sda_oe_dev);
  assign present_n = !present_oe;
  assign int_n = !int_oe;
  modport host (output scl_o_host, scl_oe_host, sda_oe_host, sel_n,
    rst_n, lp_sel, input scl, sda, present_n, int_n);
  modport dev (output sda_oe_dev, present_oe, int_oe,
    input scl, sda, sel_n, rst_n, lp_sel);
endinterface
`default_nettype wire

// *** core/mlc_module.sv ***
/*
  module end: two-wire slave gated by select, reset pin handling,
  reset-complete interrupt, low power level and present strap.
  assumes pins arrive asynchronously; core_clk runs at 50 mhz.
*/
// Functional notes
// - seven low-speed pins incl. two-wire bus
// - answer bus only while select held low
// - host gives each module its own select
// - memory map reachable over two-wire bus
// - long reset low restores all defaults
// - host ignores status until reset done
// - interrupt with data-not-ready negated signals completion
// - power-up raises completion interrupt without reset
// - low power pin caps power level
// - module grounds present line when inserted
// - interrupt low flags fault or status
// - host reads status to find source
// - interrupt is open drain, host pulls up
`timescale 1ns/100ps
`default_nettype none
module mlc_module #(
  parameter int unsigned INIT_CYCLES = mlc_pkg::INIT_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  mlc_link_if.dev link,
  input wire logic fault_in,
  output logic power_capped,
  output logic in_reset
);
  import mlc_pkg::*;
  typedef enum logic [2:0] {
    MLC_IDLE = 3'h0, MLC_ADDR = 3'h1, MLC_ACK = 3'h2,
    MLC_WDAT = 3'h3, MLC_RDAT = 3'h4, MLC_RACK = 3'h5
  } mlc_st_t;
  // three-stage samplers: [0] meta, [1],[2] compared
  logic [2:0] scl_s_q, sda_s_q, sel_s_q, rst_s_q, lp_s_q;
  logic scl_f_q, sda_f_q, sel_f_q, rst_f_q, lp_f_q; // filtered levels
  always_ff @(posedge core_clk) begin
    scl_s_q <= {scl_s_q[1:0], link.scl};
    sda_s_q <= {sda_s_q[1:0], link.sda};
    sel_s_q <= {sel_s_q[1:0], link.sel_n};
    rst_s_q <= {rst_s_q[1:0], link.rst_n};
    lp_s_q <= {lp_s_q[1:0], link.lp_sel};
  end
  // accept a change once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      sel_f_q <= 1'b1;
      rst_f_q <= 1'b1;
      lp_f_q <= 1'b1;
    end else begin
      if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
      if (sel_s_q[1] == sel_s_q[2]) sel_f_q <= sel_s_q[2];
      if (rst_s_q[1] == rst_s_q[2]) rst_f_q <= rst_s_q[2];
      if (lp_s_q[1] == lp_s_q[2]) lp_f_q <= lp_s_q[2];
    end
  end
  // bus events; select gates every start so an unselected module idles
  logic scl_p_q, sda_p_q;
  always_ff @(posedge core_clk) begin
    scl_p_q <= scl_f_q;
    sda_p_q <= sda_f_q;
  end
  wire scl_rise = scl_f_q && !scl_p_q;
  wire scl_fall = !scl_f_q && scl_p_q;
  wire start_ev = scl_f_q && sda_p_q && !sda_f_q;
  wire stop_ev = scl_f_q && !sda_p_q && sda_f_q;
  wire selected = !sel_f_q;
  // reset pin low-time counter
  logic [$clog2(RST_MIN_CYC+1)-1:0] rlow_q;
  logic pin_reset; // long low seen on reset pin
  always_ff @(posedge core_clk) begin
    if (srst || rst_f_q) rlow_q <= '0;
    else if (rlow_q != RST_MIN_CYC[$bits(rlow_q)-1:0]) rlow_q <= rlow_q + 1'b1;
  end
  assign pin_reset = (rlow_q == RST_MIN_CYC[$bits(rlow_q)-1:0]);
  wire soft_rst = srst || pin_reset; // complete reset to defaults
  // initialisation: data not ready until counter expires; srst = power-up
  logic [$clog2(INIT_CYCLES+1)-1:0] init_q;
  logic dnr_q; // data not ready
  always_ff @(posedge core_clk) begin
    if (soft_rst) begin
      init_q <= '0;
      dnr_q <= 1'b1;
    end else if (init_q != INIT_CYCLES[$bits(init_q)-1:0]) begin
      init_q <= init_q + 1'b1;
    end else begin
      dnr_q <= 1'b0; // power-up completes by itself
    end
  end
  // two-wire slave state
  mlc_st_t st_q;
  logic [3:0] bit_q;  // bit counter
  logic [7:0] sh_q;   // shift register
  logic rd_q;         // current transfer is a read
  logic have_idx_q;   // index byte already taken
  logic [7:0] idx_q;  // memory index pointer
  logic sda_oe_q;     // our pull on sda
  logic ctrl_lp_q;    // software low power force
  logic rstdone_q;    // reset done latch, cleared on read
  logic flt_q;        // fault latch, cleared on read
  logic [7:0] map_q [MAP_DEPTH]; // general user bytes
  // byte that a read returns at the index
  logic [7:0] rbyte;
  always_comb begin
    rbyte = map_q[idx_q[6:0]];
    if (idx_q == IDX_STATUS) rbyte = {7'h00, dnr_q};
    if (idx_q == IDX_FLAGS) rbyte = {6'h00, flt_q, rstdone_q};
    if (idx_q == IDX_CTRL) rbyte = {7'h00, ctrl_lp_q};
  end
  wire byte_done = scl_fall && bit_q == 4'h8;
  // flags byte is read once it is loaded for shifting out
  wire flag_rd = st_q == MLC_ACK && rd_q && scl_fall
    && idx_q == IDX_FLAGS;
  // protocol engine; gives the memory map over the bus
  always_ff @(posedge core_clk) begin
    if (soft_rst || !selected || stop_ev) begin
      st_q <= MLC_IDLE;
      sda_oe_q <= 1'b0;
      bit_q <= 4'h0;
      have_idx_q <= 1'b0;
      rd_q <= 1'b0;
      if (soft_rst) begin
        idx_q <= 8'h00;
        ctrl_lp_q <= 1'b0; // low power force back to default
      end
    end else if (start_ev) begin // start honoured only if selected
      st_q <= MLC_ADDR;
      bit_q <= 4'h0;
      have_idx_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      if (scl_rise && bit_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sda_f_q};
        bit_q <= bit_q + 4'h1;
      end
      unique case (st_q)
        MLC_IDLE: sda_oe_q <= 1'b0;
        MLC_ADDR: if (byte_done) begin
          if (sh_q[7:1] == DEV_ADDR) begin
            st_q <= MLC_ACK;
            rd_q <= sh_q[0];
            sda_oe_q <= 1'b1; // acknowledge
          end else st_q <= MLC_IDLE;
        end
        MLC_WDAT: if (byte_done) begin
          st_q <= MLC_ACK;
          sda_oe_q <= 1'b1;
          if (!have_idx_q) begin
            idx_q <= sh_q;
            have_idx_q <= 1'b1;
          end else begin
            if (idx_q == IDX_CTRL) ctrl_lp_q <= sh_q[CTRL_LP_BIT];
            else map_q[idx_q[6:0]] <= sh_q;
            idx_q <= idx_q + 8'h01;
          end
        end
        MLC_ACK: if (scl_fall) begin
          bit_q <= 4'h0;
          if (rd_q) begin
            st_q <= MLC_RDAT;
            sh_q <= rbyte;
            sda_oe_q <= !rbyte[7];
          end else begin
            st_q <= MLC_WDAT;
            sda_oe_q <= 1'b0;
          end
        end
        MLC_RDAT: if (scl_fall) begin
          if (bit_q == 4'h8) begin
            st_q <= MLC_RACK;
            sda_oe_q <= 1'b0;
            idx_q <= idx_q + 8'h01;
          end else sda_oe_q <= !sh_q[7]; // each rise shifted sh_q left
        end
        MLC_RACK: if (scl_rise) begin
          // host ack continues, nack ends
          st_q <= sda_f_q ? MLC_IDLE : MLC_ACK;
        end
        default: st_q <= MLC_IDLE;
      endcase
    end
  end
  // reset-done and fault latches; set wins over the read clear
  logic dnr_p_q;
  always_ff @(posedge core_clk) begin
    if (soft_rst) begin
      rstdone_q <= 1'b0;
      flt_q <= 1'b0;
      dnr_p_q <= 1'b1;
    end else begin
      dnr_p_q <= dnr_q;
      if (dnr_p_q && !dnr_q) rstdone_q <= 1'b1;
      else if (flag_rd) rstdone_q <= 1'b0;
      if (fault_in) flt_q <= 1'b1;
      else if (flag_rd) flt_q <= 1'b0;
    end
  end
  // output flops: interrupt, present, power cap
  logic int_oe_q, present_q, cap_q, inres_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      int_oe_q <= 1'b0;
      present_q <= 1'b1;
      cap_q <= 1'b1;
      inres_q <= 1'b1;
    end else begin
      int_oe_q <= (rstdone_q && !dnr_q) || flt_q;
      present_q <= 1'b1;
      cap_q <= lp_f_q || ctrl_lp_q;
      inres_q <= dnr_q;
    end
  end
  assign link.sda_oe_dev = sda_oe_q;
  assign link.int_oe = int_oe_q; // drives low only
  assign link.present_oe = present_q;
  assign power_capped = cap_q;
  assign in_reset = inres_q;
endmodule
`default_nettype wire

// *** sim/mlc_link_properties.sv ***
/*
  checker for the low-speed link, watching the resolved pins.
  assumes one core clock domain with the synchronous reset srst.
*/
`timescale 1ns/100ps
`default_nettype none
module mlc_link_properties (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sel_n,
  input wire logic rst_n,
  input wire logic int_n,
  input wire logic present_n,
  input wire logic sda_oe_dev
);
  logic [7:0] low_cnt_q; // cycles the reset pin has been low
  logic long_q;          // last reset pulse was long enough to act
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // saturating count of reset pin low time
  always_ff @(posedge core_clk) begin
    if (srst || rst_n) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hff) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end
  // keep the pulse length verdict past the rising edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      long_q <= 1'b0;
    end else if (!rst_n) begin
      long_q <= (low_cnt_q >= 8'h46);
    end
  end
  a_present_low: assert property (!$past(srst) |-> !present_n)
    else $error("present line not grounded");
  a_quiet_deselect: assert property (sel_n [*6] |-> !sda_oe_dev)
    else $error("module drives data while deselected");
  a_sda_scl_low: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("module data changed with clock high");
  a_reset_quiets: assert property (low_cnt_q >= 8'h50 |-> int_n)
    else $error("interrupt low during long reset");
  a_no_early_done: assert property ($rose(rst_n) && long_q |->
    int_n [*4])
    else $error("completion interrupt too early");
  a_done_after_reset: assert property ($rose(rst_n) && long_q |->
    ##[1:150] !int_n)
    else $error("no completion interrupt after reset");
  a_powerup_done: assert property ($fell(srst) |-> ##[1:150] !int_n)
    else $error("no completion interrupt after power up");
  a_int_latched: assert property (rst_n [*8] ##0 (!int_n && sel_n) |=>
    !int_n)
    else $error("interrupt left without a read");
  c_long_reset: cover property ($rose(rst_n) && long_q);
  c_dev_ack: cover property ($rose(sda_oe_dev));
  c_int_low: cover property ($fell(int_n));
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
/*
  bench: host and module joined by the link, driven over axi4-lite
  and checked against a small model. assumes a 50 mhz core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mlc_pkg::*;
  logic core_clk, srst, fault_in, power_capped, in_reset;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, s, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  integer seed;
  int bad_count, comparisons, i;
  logic [7:0] ctrl_m; // model of the control byte
  mlc_link_if link ();
  mlc_module #(.INIT_CYCLES(16)) mlc_module_inst (.core_clk, .srst,
    .link(link.dev), .fault_in, .power_capped, .in_reset);
  mlc_host mlc_host_inst (.core_clk, .srst, .link(link.host),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  mlc_link_properties mlc_link_properties_inst (.core_clk, .srst,
    .scl(link.scl), .sel_n(link.sel_n), .rst_n(link.rst_n),
    .int_n(link.int_n), .present_n(link.present_n),
    .sda_oe_dev(link.sda_oe_dev));
  // 50 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic hang(input string what);
    bad_count++;
    $display("Error %s expected completion seen timeout", what);
    complete_run();
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one axi write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang("write");
  endtask
  // one axi read into d and r
  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask
  // pin levels, then time for the module to sample them
  task automatic set_pins(input logic sel, input logic rst, input logic lp);
    axi_wr(HOFS_PINS, {29'h0, lp, rst, sel});
    repeat (8) @(posedge core_clk);
  endtask
  // one module byte over the two-wire bus; status word lands in s
  task automatic xfer(input logic wr, input logic [7:0] idx,
    input logic [7:0] dat);
    axi_wr(HOFS_CMD, {1'b1, 14'h0, wr, idx, dat});
    for (int n = 0; n < 400; n++) begin
      repeat (50) @(posedge core_clk);
      axi_rd(HOFS_STAT);
      s = d;
      if (s[8] === 1'b0) return;
    end
    hang("transfer");
  endtask
  task automatic wait_int(input logic lvl);
    for (int n = 0; n < 500; n++) begin
      @(posedge core_clk);
      if (link.int_n === lvl) return;
    end
    hang("interrupt");
  endtask
  // main sequence
  initial begin
    seed = 32'h725985d2;
    {srst, fault_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    bad_count = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    wait_int(1'b0);
    repeat (4) @(posedge core_clk); // let the sense filter settle
    axi_rd(HOFS_SENSE);
    check("sense", d[1:0], 2'b00);
    axi_rd(HOFS_PINS);
    check("pins", d[2:0], 3'b111);
    axi_rd(8'h40);
    check("unmapped", r, RESP_SLVERR);
    axi_wr(HOFS_SENSE, 32'h0);
    check("ro write", r, RESP_SLVERR);
    set_pins(1'b0, 1'b1, 1'b1);
    check("lp capped", power_capped, 1'b1);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    check("done flag", s[9:0], 10'h001);
    check("int cleared", link.int_n, 1'b1);
    set_pins(1'b0, 1'b1, 1'b0);
    for (i = 0; i < 2; i++) begin
      v = $random(seed);
      ctrl_m = v[7:0] | {7'h00, i[0]};
      xfer(1'b1, IDX_CTRL, ctrl_m);
      check("ctrl write", s[9], 1'b0);
      xfer(1'b0, IDX_CTRL, 8'h00);
      check("ctrl read", s[9:0], {9'h000, ctrl_m[0]});
      check("ctrl capped", power_capped, ctrl_m[0]);
    end
    set_pins(1'b1, 1'b1, 1'b0);
    xfer(1'b1, IDX_CTRL, ~ctrl_m);
    check("deselected", s[9], 1'b1);
    set_pins(1'b0, 1'b0, 1'b0);
    set_pins(1'b0, 1'b1, 1'b0);
    check("short reset", in_reset, 1'b0);
    xfer(1'b0, IDX_CTRL, 8'h00);
    check("ctrl kept", s[9:0], {9'h000, ctrl_m[0]});
    set_pins(1'b0, 1'b0, 1'b0);
    repeat (90) @(posedge core_clk);
    check("in reset", in_reset, 1'b1);
    check("int quiet", link.int_n, 1'b1);
    set_pins(1'b0, 1'b1, 1'b0);
    wait_int(1'b0);
    check("ready", in_reset, 1'b0);
    check("defaults", power_capped, 1'b0);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    check("done again", s[9:0], 10'h001);
    fault_in <= 1'b1;
    wait_int(1'b0);
    fault_in <= 1'b0;
    xfer(1'b0, IDX_FLAGS, 8'h00);
    check("fault flag", s[9:0], 10'h002);
    complete_run();
  end
endmodule
`default_nettype wire
